// *** src/reset_cause_status.v ***
// Reset cause flags, start-up delay selection and reload values
// Behaviour
// R1: Power status register holds at most two bits, count set by variant.
// R2: Brownout flag sits at bit 0; left as is after power-on.
// R3: Brown-out reset clears the brownout flag.
// R4: Software sets the brownout flag to one after power-on.
// R5: Poweron flag at bit 1 cleared on power-on only.
// R6: Software sets the poweron flag after each power-on.
// R7: Brownout flag meaningless while brown-out detection is off.
// R8: Crystal modes: 72 ms plus 1024 periods, or 1024 alone.
// R9: RC mode: 72 ms on enabled power-up and brown-out, else none.
// R10: Power-on sets watchdog and powerdown flags, clears poweron flag.
// R11: Brown-out, watchdog reset and watchdog wake report their flag pairs.
// R12: Master clear while running keeps time flags, clears upper bits.
// R13: Master clear in sleep or irq wake: watchdog 1, powerdown 0.
// R14: Resets load PC 000h; wake-ups continue at next address.
// R15: Irq wake with global enable loads the interrupt vector.
// R16: Three init classes; option and direction reload to all ones.
// R17: Start-up count of 1024 periods follows the power-up delay.
// R18: Brown-out detection forces the power-up delay on.
// R19: Flags update in the cycle the reset event arrives.
`timescale 1ns/1ps
`include "reset_cause_map.vh"

module reset_cause_status #(
  parameter                   HAS_BROWNOUT_BIT = 1,
  parameter [`POWERUP_TIMER_CNT_W-1:0] POWERUP_TIMER_CYCLES      =
    `POWERUP_TIMER_TIME_MS * `HCLK_FREQ_KHZ
) (
  input  wire                 hclk,
  input  wire                 hresetn,
  input  wire                 hsel,
  input  wire [31:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output wire                 hreadyout,
  output wire                 hresp,
  output reg  [31:0]          hrdata,
  input  wire                 por_event,
  input  wire                 brownout_event,
  input  wire                 master_clear_event,
  input  wire                 watchdog_timer_expire,
  input  wire                 irq_wake_event,
  input  wire                 core_in_sleep,
  input  wire                 global_irq_enable,
  input  wire [`PC_W-1:0]     next_pc,
  input  wire                 osc_tick,
  output wire                 core_reset_hold,
  output reg                  pc_load,
  output reg  [`PC_W-1:0]     pc_load_value,
  output reg  [2:0]           init_class,
  output reg  [7:0]           option_dir_value,
  output wire                 irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg                    brownout_flag;
  reg                    poweron_flag;
  reg                    watchdog_expired_flag;
  reg                    powerdown_flag;
  reg  [2:0]             status_upper;
  reg  [2:0]             status_lower;
  reg  [3:0]             config_bits;
  reg  [`EVT_BITS-1:0]   event_status;
  reg  [`EVT_BITS-1:0]   event_mask;
  reg  [`EVT_BITS-1:0]   next_event_status;
  reg                    dp_wr;
  reg                    dp_rd;
  reg                    rd_done;
  reg  [7:0]             dp_addr;
  reg                    timer_start;
  reg                    timer_use_powerup_timer;
  reg                    timer_use_ost;
  wire                   timer_busy;
  wire                   timer_done;
  wire                   addr_phase;
  wire                   wr_now;
  wire [1:0]             osc_mode;
  wire                   powerup_timer_en_n;
  wire                   bod_en;
  wire                   bor_seen;
  wire                   wdt_wake;
  wire                   wdt_reset;
  wire                   master_clear_pin_sleep;
  wire                   master_clear_pin_run;
  wire                   irq_wake;
  wire                   any_event;
  wire [`EVT_BITS-1:0]   event_hits;

  // Oscillator classes that need the start-up count
  function osc_is_crystal;
    input [1:0] mode;
    begin
      osc_is_crystal = (mode != `OSC_RC);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and event decode
  assign osc_mode  = config_bits[`CFG_OSC_HI:`CFG_OSC_LO];
  assign powerup_timer_en_n = config_bits[`CFG_POWERUP_TIMER_EN_N];
  assign bod_en    = config_bits[`CFG_BOD_EN];

  // Brown-out events are dropped while detection is off [R7]
  assign bor_seen   = brownout_event & bod_en & ~por_event;
  assign master_clear_pin_sleep = master_clear_event & core_in_sleep;
  assign master_clear_pin_run   = master_clear_event & ~core_in_sleep;
  assign wdt_wake   = watchdog_timer_expire & core_in_sleep;
  assign wdt_reset  = watchdog_timer_expire & ~core_in_sleep;
  assign irq_wake   = irq_wake_event & core_in_sleep;
  assign any_event  = por_event | bor_seen | master_clear_event |
                      watchdog_timer_expire | irq_wake;

  // Priority: power-on, brown-out, master clear, watchdog, interrupt
  assign event_hits[`EVT_POR]          = por_event;
  assign event_hits[`EVT_BOR]          = bor_seen;
  assign event_hits[`EVT_MASTER_CLEAR_PIN_RUN]     = ~por_event & ~bor_seen & master_clear_pin_run;
  assign event_hits[`EVT_MASTER_CLEAR_PIN_SLEEP]   = ~por_event & ~bor_seen & master_clear_pin_sleep;
  assign event_hits[`EVT_WDT_RESET]    = ~por_event & ~bor_seen &
                                         ~master_clear_event & wdt_reset;
  assign event_hits[`EVT_WDT_WAKE]     = ~por_event & ~bor_seen &
                                         ~master_clear_event & wdt_wake;
  assign event_hits[`EVT_IRQ_WAKE]     = ~por_event & ~bor_seen &
                                         ~master_clear_event &
                                         ~watchdog_timer_expire & irq_wake;
  assign event_hits[`EVT_STARTUP_DONE] = timer_done;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero-wait writes, one wait state on reads
  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout  = ~(dp_rd & ~rd_done);
  assign hresp      = 1'b0;
  assign wr_now     = dp_wr;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      rd_done <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      if (hready) begin
        dp_wr   <= addr_phase & hwrite;
        dp_rd   <= addr_phase & ~hwrite;
        rd_done <= 1'b0;
        if (addr_phase) begin
          dp_addr <= haddr[7:0];
        end
      end else if (dp_rd & ~rd_done) begin
        // Sampled after any earlier write has landed
        rd_done <= 1'b1;
        case (dp_addr)
          `OFS_POWER_STATUS: begin
            hrdata <= {30'h0, poweron_flag,
                       brownout_flag & (HAS_BROWNOUT_BIT != 0)}; // [R1] [R2]
          end
          `OFS_CORE_STATUS: begin
            hrdata <= {24'h0, status_upper, watchdog_expired_flag,
                       powerdown_flag, status_lower};
          end
          `OFS_CONFIG: begin
            hrdata <= {28'h0, config_bits};
          end
          `OFS_EVENT_STATUS: begin
            hrdata <= {24'h0, event_status};
          end
          `OFS_EVENT_MASK: begin
            hrdata <= {24'h0, event_mask};
          end
          `OFS_PC_LOAD: begin
            hrdata <= {13'h0, init_class, 3'h0, pc_load_value};
          end
          `OFS_STARTUP: begin
            hrdata <= {31'h0, timer_busy};
          end
          default: begin
            hrdata <= 32'h0000_0000; // Unmapped reads as zero
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags; a hardware event in the same cycle beats a write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brownout_flag         <= 1'b0;
      poweron_flag          <= 1'b0;
      watchdog_expired_flag <= 1'b1;
      powerdown_flag        <= 1'b1;
      status_upper          <= 3'h0;
      status_lower          <= 3'h0;
    end else if (por_event) begin
      // Brownout flag left unknown-as-is on power-on [R2]
      poweron_flag          <= 1'b0; // [R5] [R10] [R19]
      watchdog_expired_flag <= 1'b1; // [R10]
      powerdown_flag        <= 1'b1; // [R10]
      status_upper          <= 3'h0; // [R10]
    end else if (bor_seen) begin
      brownout_flag         <= 1'b0; // [R3] [R11] [R19]
      watchdog_expired_flag <= 1'b1; // [R11]
      powerdown_flag        <= 1'b1; // [R11]
      status_upper          <= 3'h0;
    end else if (master_clear_pin_run) begin
      status_upper          <= 3'h0; // Time flags kept [R12]
    end else if (master_clear_pin_sleep) begin
      watchdog_expired_flag <= 1'b1; // [R13]
      powerdown_flag        <= 1'b0; // [R13]
      status_upper          <= 3'h0;
    end else if (wdt_reset) begin
      watchdog_expired_flag <= 1'b0; // [R11]
      powerdown_flag        <= 1'b1; // [R11]
      status_upper          <= 3'h0;
    end else if (wdt_wake) begin
      watchdog_expired_flag <= 1'b0; // [R11]
      powerdown_flag        <= 1'b0; // [R11]
    end else if (irq_wake) begin
      watchdog_expired_flag <= 1'b1; // [R13]
      powerdown_flag        <= 1'b0; // [R13]
    end else if (wr_now && dp_addr == `OFS_POWER_STATUS) begin
      // Software arms both flags after power-on [R4] [R6]
      poweron_flag  <= hwdata[`BIT_POWERON];
      brownout_flag <= hwdata[`BIT_BROWNOUT] & (HAS_BROWNOUT_BIT != 0);
    end else if (wr_now && dp_addr == `OFS_CORE_STATUS) begin
      status_upper <= hwdata[7:5]; // Time flags are read-only
      status_lower <= hwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, mask and sticky event status (set wins over clear)
  always @* begin
    next_event_status = event_status;
    if (wr_now && dp_addr == `OFS_EVENT_STATUS) begin
      next_event_status = event_status & ~hwdata[`EVT_BITS-1:0];
    end
    next_event_status = next_event_status | event_hits;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_bits  <= `CFG_RESET;
      event_mask   <= {`EVT_BITS{1'b0}};
      event_status <= {`EVT_BITS{1'b0}};
    end else begin
      event_status <= next_event_status;
      if (wr_now && dp_addr == `OFS_CONFIG) begin
        config_bits <= hwdata[3:0];
      end
      if (wr_now && dp_addr == `OFS_EVENT_MASK) begin
        event_mask <= hwdata[`EVT_BITS-1:0];
      end
    end
  end

  assign irq = |(event_status & event_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Start-up delay selection per oscillator class and event
  always @* begin
    timer_start    = 1'b0;
    timer_use_powerup_timer = 1'b0;
    timer_use_ost  = 1'b0;
    if (por_event) begin
      timer_start    = 1'b1;
      // Detection on forces the delay regardless of its enable [R18]
      timer_use_powerup_timer = ~powerup_timer_en_n | bod_en; // [R8] [R9]
      timer_use_ost  = osc_is_crystal(osc_mode); // [R8] [R17]
    end else if (bor_seen) begin
      timer_start    = 1'b1;
      timer_use_powerup_timer = 1'b1; // [R8] [R9] [R18]
      timer_use_ost  = osc_is_crystal(osc_mode); // [R8]
    end else if (~master_clear_event & (wdt_wake | irq_wake)) begin
      // Wake from sleep: count only in crystal modes, none in RC [R9]
      timer_start    = osc_is_crystal(osc_mode); // [R8]
      timer_use_ost  = osc_is_crystal(osc_mode);
    end
  end

  startup_delay_timer #(
    .POWERUP_TIMER_CYCLES (POWERUP_TIMER_CYCLES)
  ) u_startup (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (timer_start),
    .use_powerup_timer (timer_use_powerup_timer),
    .use_ost  (timer_use_ost),
    .osc_tick (osc_tick),
    .busy     (timer_busy),
    .done     (timer_done)
  );

  // Core held while an event is present or the delay runs
  assign core_reset_hold = any_event | timer_busy | timer_start;

  ////////////////////////////////////////////////////////////////////////////
  // Program counter reload and register init class
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_load          <= 1'b0;
      pc_load_value    <= `PC_RESET_VEC;
      init_class       <= 3'b001;
      option_dir_value <= `OPT_DIR_RESET;
    end else begin
      pc_load <= any_event;
      if (por_event | bor_seen) begin
        pc_load_value    <= `PC_RESET_VEC; // [R14]
        init_class       <= 3'b001; // [R16]
        option_dir_value <= `OPT_DIR_RESET; // [R16]
      end else if (master_clear_event | wdt_reset) begin
        pc_load_value    <= `PC_RESET_VEC; // [R14]
        init_class       <= 3'b010; // [R16]
        option_dir_value <= `OPT_DIR_RESET; // [R16]
      end else if (wdt_wake) begin
        pc_load_value <= next_pc; // [R14]
        init_class    <= 3'b100; // Contents kept [R16]
      end else if (irq_wake) begin
        // Vector only when interrupts are globally enabled [R15]
        pc_load_value <= global_irq_enable ? `PC_IRQ_VEC : next_pc;
        init_class    <= 3'b100; // [R16]
      end
    end
  end

endmodule // reset_cause_status

// *** common/reset_cause_map.vh ***
// Register map, field positions, reset values and timing counts
`ifndef RESET_CAUSE_MAP_VH
`define RESET_CAUSE_MAP_VH

// Register byte offsets
`define OFS_POWER_STATUS  8'h00
`define OFS_CORE_STATUS   8'h04
`define OFS_CONFIG        8'h08
`define OFS_EVENT_STATUS  8'h0c
`define OFS_EVENT_MASK    8'h10
`define OFS_PC_LOAD       8'h14
`define OFS_STARTUP       8'h18

// Power status fields
`define PWR_STAT_BITS     2
`define BIT_BROWNOUT      0
`define BIT_POWERON       1

// Core status fields (byte layout of the core status word)
`define BIT_WDT_EXPIRED   4
`define BIT_POWERDOWN     3

// Configuration fields and reset value
`define CFG_OSC_LO        0
`define CFG_OSC_HI        1
`define CFG_POWERUP_TIMER_EN_N     2
`define CFG_BOD_EN        3
`define CFG_RESET         4'h1

// Oscillator classes
`define OSC_LP            2'h0
`define OSC_XT            2'h1
`define OSC_HS            2'h2
`define OSC_RC            2'h3

// Event bits
`define EVT_POR           0
`define EVT_BOR           1
`define EVT_WDT_RESET     2
`define EVT_WDT_WAKE      3
`define EVT_MASTER_CLEAR_PIN_RUN      4
`define EVT_MASTER_CLEAR_PIN_SLEEP    5
`define EVT_IRQ_WAKE      6
`define EVT_STARTUP_DONE  7
`define EVT_BITS          8

// Program counter reload values
`define PC_W              13
`define PC_RESET_VEC      13'h0000
`define PC_IRQ_VEC        13'h0004

// Option and direction registers reload to all ones
`define OPT_DIR_RESET     8'hff

// Timing: power-up delay, clock rate, oscillator start-up count
`define POWERUP_TIMER_TIME_MS      72
`define HCLK_FREQ_KHZ     40000
`define POWERUP_TIMER_CNT_W        22
`define OST_PERIODS       11'h400
`define OST_CNT_W         11

`endif

// *** src/startup_delay_timer.v ***
// Power-up delay followed by oscillator start-up count
`timescale 1ns/1ps
`include "reset_cause_map.vh"

module startup_delay_timer #(
  parameter [`POWERUP_TIMER_CNT_W-1:0] POWERUP_TIMER_CYCLES = 22'd2880000
) (
  input  wire hclk,
  input  wire hresetn,
  input  wire start,
  input  wire use_powerup_timer,
  input  wire use_ost,
  input  wire osc_tick,
  output wire busy,
  output reg  done
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_POWERUP_TIMER = 3'b010;
  localparam [2:0] ST_OST  = 3'b100;

  reg [2:0]             state;
  reg [`POWERUP_TIMER_CNT_W-1:0] powerup_timer_cnt;
  reg [`OST_CNT_W-1:0]  ost_cnt;
  reg                   ost_wanted;

  assign busy = ~state[0];

  ////////////////////////////////////////////////////////////////////////////
  // A new start always restarts, so a brown-out inside the delay begins again
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_IDLE;
      powerup_timer_cnt   <= {`POWERUP_TIMER_CNT_W{1'b0}};
      ost_cnt    <= {`OST_CNT_W{1'b0}};
      ost_wanted <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        ost_wanted <= use_ost;
        powerup_timer_cnt   <= POWERUP_TIMER_CYCLES;
        ost_cnt    <= `OST_PERIODS;
        if (use_powerup_timer) begin
          state <= ST_POWERUP_TIMER;
        end else if (use_ost) begin
          state <= ST_OST;
        end else begin
          state <= ST_IDLE;
          done  <= 1'b1;
        end
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          ST_POWERUP_TIMER: begin
            if (powerup_timer_cnt == {{(`POWERUP_TIMER_CNT_W-1){1'b0}}, 1'b1}) begin
              // Start-up count begins only after the power-up delay [R17]
              if (ost_wanted) begin
                state <= ST_OST;
              end else begin
                state <= ST_IDLE;
                done  <= 1'b1;
              end
            end
            powerup_timer_cnt <= powerup_timer_cnt - {{(`POWERUP_TIMER_CNT_W-1){1'b0}}, 1'b1};
          end
          ST_OST: begin
            // Oscillator periods arrive as single-cycle ticks [R17]
            if (osc_tick) begin
              if (ost_cnt == {{(`OST_CNT_W-1){1'b0}}, 1'b1}) begin
                state <= ST_IDLE;
                done  <= 1'b1;
              end
              ost_cnt <= ost_cnt - {{(`OST_CNT_W-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // startup_delay_timer

// *** tb/reset_cause_properties.sv ***
// Port-level checks for the reset cause block
`timescale 1ns/1ps
`include "reset_cause_map.vh"
module reset_cause_checks (
  input wire             hclk,
  input wire             hresetn,
  input wire             hsel,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire             hready,
  input wire             hreadyout,
  input wire             por_event,
  input wire             brownout_event,
  input wire             master_clear_event,
  input wire             watchdog_timer_expire,
  input wire             irq_wake_event,
  input wire             core_in_sleep,
  input wire             global_irq_enable,
  input wire [`PC_W-1:0] next_pc,
  input wire             core_reset_hold,
  input wire             pc_load,
  input wire [`PC_W-1:0] pc_load_value,
  input wire [2:0]       init_class,
  input wire [7:0]       option_dir_value
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Request and wake sequences; higher priority causes must be absent
  sequence rd_req;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence no_reset_cause;
    !por_event && !brownout_event && !master_clear_event;
  endsequence
  sequence wdt_wake;
    no_reset_cause ##0 watchdog_timer_expire && core_in_sleep;
  endsequence
  sequence irq_wake;
    no_reset_cause ##0 !watchdog_timer_expire && irq_wake_event
      && core_in_sleep;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  rd_wait_a: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  por_vector_a: assert property (
    por_event |=> pc_load_value == `PC_RESET_VEC)
    else $error("power-on did not reload address zero");
  por_class_a: assert property (
    por_event |=> init_class == 3'h1 && option_dir_value == 8'hff)
    else $error("power-on init class wrong");
  master_clear_pin_class_a: assert property (
    master_clear_event && !por_event && !brownout_event
      |=> init_class == 3'h2 && option_dir_value == 8'hff)
    else $error("master clear init class wrong");
  wake_next_a: assert property (
    wdt_wake |=> pc_load_value == $past(next_pc))
    else $error("watchdog wake did not continue at next address");
  irq_vector_a: assert property (
    irq_wake ##0 global_irq_enable |=> pc_load_value == `PC_IRQ_VEC)
    else $error("interrupt wake missed the vector");
  wake_class_a: assert property (
    wdt_wake |=> init_class == 3'h4
      && option_dir_value == $past(option_dir_value))
    else $error("wake-up disturbed preserved values");
  hold_event_a: assert property (
    por_event || master_clear_event |-> core_reset_hold)
    else $error("core not held during reset event");
  load_pulse_a: assert property (
    por_event || master_clear_event || watchdog_timer_expire |=> pc_load)
    else $error("program counter reload not pulsed");
  load_idle_a: assert property (
    !por_event && !brownout_event && !master_clear_event
      && !watchdog_timer_expire && !irq_wake_event |=> !pc_load)
    else $error("program counter reload without an event");
endmodule // reset_cause_checks

// *** tb/tb_top.sv ***
// Self-checking bench for the reset cause block
`timescale 1ns/1ps
`include "reset_cause_map.vh"
module tb_top;
  localparam integer P = 20;
  localparam integer T = 2048;
  reg               hclk = 1'b0;
  reg               hresetn = 1'b0;
  reg               hsel = 1'b0;
  reg               hwrite = 1'b0;
  reg  [1:0]        htrans = 2'h0;
  reg  [2:0]        hsize = 3'h2;
  reg  [31:0]       haddr = 32'h0;
  reg  [31:0]       hwdata = 32'h0;
  reg  [4:0]        evt = 5'h0;
  reg               core_in_sleep = 1'b0;
  reg               global_irq_enable = 1'b0;
  reg  [`PC_W-1:0]  next_pc = 13'h0123;
  reg               osc_tick = 1'b0;
  wire              hready;
  wire              hreadyout;
  wire              hresp;
  wire [31:0]       hrdata;
  wire              core_reset_hold;
  wire              pc_load;
  wire [`PC_W-1:0]  pc_load_value;
  wire [2:0]        init_class;
  wire [7:0]        option_dir_value;
  wire              irq;
  reg  [31:0]       rd_last;
  integer           bad_count = 0;
  integer           checks = 0;
  integer           cycles = 0;
  integer           n;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  reset_cause_status #(.POWERUP_TIMER_CYCLES(22'd20)) u_reset_cause_status (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .por_event(evt[0]),
    .brownout_event(evt[1]), .master_clear_event(evt[2]),
    .watchdog_timer_expire(evt[3]), .irq_wake_event(evt[4]),
    .core_in_sleep, .global_irq_enable, .next_pc, .osc_tick,
    .core_reset_hold, .pc_load, .pc_load_value, .init_class,
    .option_dir_value, .irq);
  // Clock, and an oscillator tick every other cycle
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    osc_tick <= ~osc_tick;
  end
  // Hang guard: well above the longest sequence of start-up delays
  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready sampled at the falling edge, where it has settled
  task hrdy;
    reg r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd_last = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hrdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hrdy;
  endtask
  task rdchk(input [7:0] a, input [31:0] m, input [31:0] e, input string s);
    bus(a, 1'b0, 32'h0);
    chk(rd_last & m, e, s);
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask
  // One-cycle event pulse, then count the cycles the core is held
  task fire(input integer i, output integer c);
    @(posedge hclk);
    evt[i] <= 1'b1;
    @(posedge hclk);
    evt[i] <= 1'b0;
    c = 0;
    @(negedge hclk);
    while (core_reset_hold === 1'b1 && c < 5000) begin
      c = c + 1;
      @(negedge hclk);
    end
  endtask
  task rcase(input s, input g, input integer i, input [31:0] ec,
             input [31:0] ep);
    bus(`OFS_CORE_STATUS, 1'b1, 32'he5);
    core_in_sleep <= s;
    global_irq_enable <= g;
    fire(i, n);
    rdchk(`OFS_CORE_STATUS, 32'hff, ec, "core_status");
    rdchk(`OFS_POWER_STATUS, 32'h3, 32'h3, "power_status");
    rdchk(`OFS_PC_LOAD, 32'h7_1fff, ep, "pc_and_class");
  endtask
  // Tolerance covers the tick phase and the start and done cycles
  task tcase(input [3:0] c, input integer i, input s, input integer e);
    bus(`OFS_CONFIG, 1'b1, {28'h0, c});
    core_in_sleep <= s;
    fire(i, n);
    chk({31'h0, n >= e - 2 && n <= e + 4}, 32'h1, "hold_cycles");
  endtask
  task irq_is(input e);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e}, "irq");
  endtask
  task report_and_stop;
    $display("Checks %0d, errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`OFS_POWER_STATUS, 32'h2, 32'h0, "poweron");
    rdchk(`OFS_CORE_STATUS, 32'hf8, 32'h18, "core_status");
    rdchk(`OFS_CONFIG, 32'hf, 32'h1, "config");
    rdchk(8'h1c, 32'hffffffff, 32'h0, "unmapped");
    bus(`OFS_POWER_STATUS, 1'b1, 32'hffffffff);
    rdchk(`OFS_POWER_STATUS, 32'hffffffff, 32'h3, "power");
    bus(`OFS_CORE_STATUS, 1'b1, 32'h0);
    rdchk(`OFS_CORE_STATUS, 32'hff, 32'h18, "core_ro");
    rcase(1'b0, 1'b0, 2, 32'h1d, 32'h2_0000);
    rcase(1'b0, 1'b0, 3, 32'h0d, 32'h2_0000);
    rcase(1'b1, 1'b0, 2, 32'h15, 32'h2_0000);
    rcase(1'b1, 1'b0, 3, 32'he5, 32'h4_0123);
    rcase(1'b1, 1'b1, 4, 32'hf5, 32'h4_0004);
    rcase(1'b1, 1'b0, 4, 32'hf5, 32'h4_0123);
    core_in_sleep <= 1'b0;
    fire(0, n);
    rdchk(`OFS_POWER_STATUS, 32'h3, 32'h1, "power_por");
    rdchk(`OFS_CORE_STATUS, 32'hf8, 32'h18, "core_por");
    rdchk(`OFS_PC_LOAD, 32'h7_1fff, 32'h1_0000, "pc_por");
    bus(`OFS_CONFIG, 1'b1, 32'h9);
    bus(`OFS_POWER_STATUS, 1'b1, 32'h3);
    bus(`OFS_CORE_STATUS, 1'b1, 32'he5);
    fire(1, n);
    rdchk(`OFS_POWER_STATUS, 32'h3, 32'h2, "power_bor");
    rdchk(`OFS_CORE_STATUS, 32'hff, 32'h1d, "core_bor");
    tcase(4'h1, 0, 1'b0, P + T);
    tcase(4'h5, 0, 1'b0, T);
    tcase(4'h2, 0, 1'b0, P + T);
    tcase(4'h3, 0, 1'b0, P);
    tcase(4'h7, 0, 1'b0, 0);
    tcase(4'hf, 0, 1'b0, P);
    tcase(4'h9, 1, 1'b0, P + T);
    tcase(4'hb, 1, 1'b0, P);
    // Clear first, so the wake-up count below leaves a fresh done event
    bus(`OFS_EVENT_STATUS, 1'b1, 32'hff);
    tcase(4'h0, 3, 1'b1, T);
    tcase(4'h3, 4, 1'b1, 0);
    bus(`OFS_EVENT_MASK, 1'b1, 32'h10);
    core_in_sleep <= 1'b0;
    fire(2, n);
    rdchk(`OFS_EVENT_STATUS, 32'h90, 32'h90, "events");
    irq_is(1'b1);
    bus(`OFS_EVENT_MASK, 1'b1, 32'h0);
    irq_is(1'b0);
    bus(`OFS_EVENT_MASK, 1'b1, 32'h10);
    irq_is(1'b1);
    bus(`OFS_EVENT_STATUS, 1'b1, 32'h10);
    irq_is(1'b0);
    report_and_stop;
  end
endmodule // tb_top
bind reset_cause_status reset_cause_checks u_reset_cause_checks (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .por_event, .brownout_event, .master_clear_event, .watchdog_timer_expire,
  .irq_wake_event, .core_in_sleep, .global_irq_enable, .next_pc,
  .core_reset_hold, .pc_load, .pc_load_value, .init_class,
  .option_dir_value);
